// ==== design/idf_pkg.sv ====
package idf_pkg;

  localparam int unsigned NUM_CH        = 16;
  localparam int unsigned NUM_GRP       = 4;
  localparam int unsigned CH_PER_GRP    = 4;

  // Timing: module clock, millisecond base and dechatter window unit.
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam int unsigned WIN_UNIT_MS   = 100;

  // Debounce type encodings.
  localparam logic        DBT_STEADY    = 1'h0;
  localparam logic        DBT_INTEG     = 1'h1;

  // Edge selector encodings.
  localparam logic [1:0]  EDGE_BOTH     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;

  // Reset values of the configuration.
  localparam logic [7:0]  DEF_DEB_MS    = 8'h01;
  localparam logic [7:0]  DEF_CHAT_CNT  = 8'h01;
  localparam logic [7:0]  DEF_CHAT_TIME = 8'h01;
  localparam logic        DEF_DECH_EN   = 1'h1;
  localparam logic        DEF_USED      = 1'h1;
  localparam logic        DEF_CNT_MODE  = 1'h0;

  typedef struct packed {
    logic       used;
    logic [7:0] deb_ms;
    logic [1:0] edge_sel;
    logic [7:0] chat_cnt;
    logic [7:0] chat_time;
  } idf_ch_cfg_t;

  typedef struct packed {
    logic deb_type;
    logic cnt_mode;
    logic dech_en;
  } idf_grp_cfg_t;

  typedef struct packed {
    logic level;
    logic valid;
    logic rising;
    logic dech_act;
  } idf_ch_out_t;

  localparam idf_ch_cfg_t  CH_CFG_DEF  = '{used: DEF_USED, deb_ms: DEF_DEB_MS, edge_sel: EDGE_BOTH,
                                          chat_cnt: DEF_CHAT_CNT, chat_time: DEF_CHAT_TIME};
  localparam idf_grp_cfg_t GRP_CFG_DEF = '{deb_type: DBT_STEADY, cnt_mode: DEF_CNT_MODE,
                                          dech_en: DEF_DECH_EN};

endpackage

// ==== design/idf_tick.sv ====
`timescale 1ns/1ps
// Divides qualifying enable pulses by DIV and emits one pulse per DIV of them.
module idf_tick #(
  parameter int unsigned DIV = 40000
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic en,
  output logic      tick
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (en)
    begin
      if (cnt_r == LAST)
      begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule

// ==== design/idf_top.sv ====
`timescale 1ns/1ps
// What this block does
// R1 - Debounce time 0 to 255 ms per channel; zero passes raw input through.
// R2 - Debounce time defaults to one millisecond after defaults load.
// R3 - Each four-channel group picks steady-state (0) or integrating (1) filtering.
// R4 - Steady-state accepts a level held longer than filter time; transitions restart timing.
// R5 - Integrating accepts once accumulated time at new level reaches filter time.
// R6 - Filtered edge lags raw edge by the debounce delay.
// R7 - Software should program at least one millisecond debounce; not enforced.
// R8 - Time stamping channels detect both filtered edges regardless of edge selector.
// R9 - Edge selector: 0 both, 1 rising, 2 falling; single edges only when counting.
// R10 - Dechatter records first N edges (1 to 255) per window, discards others.
// R11 - Dechatter window is 1 to 255 units of 100 ms, default one.
// R12 - Window starts at first edge when idle or after expiry; none without edges.
// R13 - Group dechatter enable, default on; disabled passes every edge unlimited.
// R14 - Discard sets dechatter-active; window expiry clears it.
// R15 - No polarity alternation enforced among recorded edges.
// R16 - Disabled channel reports level zero and produces no edges.
// R17 - Order: debounce, edge detection on filtered level, dechatter, then recording.
// R18 - Integrating uses ms up/down accumulator; level toggles when count reaches time.
module idf_top
  import idf_pkg::*;
#(
  parameter int unsigned MS_DIV  = idf_pkg::MS_CYCLES,
  parameter int unsigned WIN_DIV = idf_pkg::WIN_UNIT_MS
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [idf_pkg::NUM_CH-1:0]    raw_in,
  input  wire logic                          cfg_wr,
  input  wire logic                          cfg_def,
  input  idf_pkg::idf_ch_cfg_t               ch_cfg_in  [idf_pkg::NUM_CH],
  input  idf_pkg::idf_grp_cfg_t              grp_cfg_in [idf_pkg::NUM_GRP],
  output idf_pkg::idf_ch_out_t               ch_out     [idf_pkg::NUM_CH]
);
  import idf_pkg::*;

  logic ms_tick;
  logic win_tick;

  idf_tick #(.DIV(MS_DIV)) u_ms_tick (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .en    (1'b1),
    .tick  (ms_tick)
  );

  idf_tick #(.DIV(WIN_DIV)) u_win_tick (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .en    (ms_tick),
    .tick  (win_tick)
  );

  // Configuration is captured on a write strobe so a live change cannot tear mid-cycle.
  idf_ch_cfg_t  ch_cfg_r   [NUM_CH];
  idf_ch_cfg_t  ch_cfg_nxt [NUM_CH];
  idf_grp_cfg_t grp_cfg_r   [NUM_GRP];
  idf_grp_cfg_t grp_cfg_nxt [NUM_GRP];

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      ch_cfg_nxt[i] = ch_cfg_r[i];
      if (cfg_def)
        ch_cfg_nxt[i] = CH_CFG_DEF; // R2
      else if (cfg_wr)
        ch_cfg_nxt[i] = ch_cfg_in[i];
    end
    for (int g = 0; g < NUM_GRP; g++)
    begin
      grp_cfg_nxt[g] = grp_cfg_r[g];
      if (cfg_def)
        grp_cfg_nxt[g] = GRP_CFG_DEF; // R13
      else if (cfg_wr)
        grp_cfg_nxt[g] = grp_cfg_in[g];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        ch_cfg_r[i] <= CH_CFG_DEF; // R2
      for (int g = 0; g < NUM_GRP; g++)
        grp_cfg_r[g] <= GRP_CFG_DEF;
    end
    else if (ce)
    begin
      ch_cfg_r  <= ch_cfg_nxt;
      grp_cfg_r <= grp_cfg_nxt;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      idf_ch_cfg_t  cc;
      idf_grp_cfg_t gc;
      logic         raw_prev_r;
      logic         raw_prev_nxt;
      logic         lvl_r;
      logic         lvl_nxt;
      logic [7:0]   acc_r;
      logic [7:0]   acc_nxt;
      logic         rise;
      logic         fall;
      logic         qual;
      logic         win_on_r;
      logic         win_on_nxt;
      logic [7:0]   win_left_r;
      logic [7:0]   win_left_nxt;
      logic [7:0]   ecnt_r;
      logic [7:0]   ecnt_nxt;
      logic         act_r;
      logic         act_nxt;
      logic         pass;
      idf_ch_out_t  out_nxt;
      idf_ch_out_t  out_r;

      assign cc = ch_cfg_r[c];
      assign gc = grp_cfg_r[c / CH_PER_GRP];

      // Debounce stage; its delay is the latency seen by time stamping downstream.
      always_comb
      begin
        raw_prev_nxt = raw_in[c];
        lvl_nxt      = lvl_r;
        acc_nxt      = acc_r;
        if (!cc.used)
        begin
          lvl_nxt = 1'b0; // R16
          acc_nxt = 8'h00;
        end
        else if (cc.deb_ms == 8'h00)
        begin
          lvl_nxt = raw_in[c]; // R1
          acc_nxt = 8'h00;
        end
        else if (gc.deb_type == DBT_STEADY) // R3
        begin
          if (raw_in[c] == lvl_r || raw_in[c] != raw_prev_r)
            acc_nxt = 8'h00; // R4
          else if (ms_tick)
          begin
            // Holding through a further tick after reaching the time means strictly longer.
            if (acc_r >= cc.deb_ms)
            begin
              lvl_nxt = raw_in[c]; // R4
              acc_nxt = 8'h00;
            end
            else
              acc_nxt = acc_r + 8'h01;
          end
        end
        else if (ms_tick)
        begin
          if (raw_in[c] != lvl_r)
          begin
            if (acc_r + 8'h01 >= cc.deb_ms)
            begin
              lvl_nxt = ~lvl_r; // R18
              acc_nxt = 8'h00;
            end
            else
              acc_nxt = acc_r + 8'h01; // R5
          end
          else if (acc_r != 8'h00)
            acc_nxt = acc_r - 8'h01; // R5
        end
      end

      // Edge detection runs on the filtered level only.
      always_comb
      begin
        rise = cc.used && lvl_nxt && !lvl_r; // R17
        fall = cc.used && !lvl_nxt && lvl_r; // R17
        qual = rise || fall; // R8
        if (gc.cnt_mode)
        begin
          if (cc.edge_sel == EDGE_RISE)
            qual = rise; // R9
          else if (cc.edge_sel == EDGE_FALL)
            qual = fall; // R9
        end
      end

      // Dechatter stage; expiry is handled first so an edge in that cycle opens a fresh window.
      always_comb
      begin
        win_on_nxt   = win_on_r;
        win_left_nxt = win_left_r;
        ecnt_nxt     = ecnt_r;
        act_nxt      = act_r;
        pass         = 1'b0;
        if (win_on_r && win_tick)
        begin
          if (win_left_r <= 8'h01)
          begin
            win_on_nxt = 1'b0; // R12
            act_nxt    = 1'b0; // R14
          end
          else
            win_left_nxt = win_left_r - 8'h01; // R11
        end
        if (!gc.dech_en)
        begin
          pass       = qual; // R13
          win_on_nxt = 1'b0;
          act_nxt    = 1'b0;
        end
        else if (qual)
        begin
          if (!win_on_nxt)
          begin
            pass         = 1'b1; // R12
            win_on_nxt   = 1'b1;
            win_left_nxt = cc.chat_time; // R11
            ecnt_nxt     = 8'h01;
          end
          else if (ecnt_r < cc.chat_cnt)
          begin
            pass     = 1'b1; // R10
            ecnt_nxt = ecnt_r + 8'h01; // R15
          end
          else
            act_nxt = 1'b1; // R14
        end
        if (!cc.used)
        begin
          win_on_nxt = 1'b0;
          act_nxt    = 1'b0;
        end
        out_nxt.level    = lvl_nxt; // R6
        out_nxt.valid    = pass;
        out_nxt.rising   = rise;
        out_nxt.dech_act = act_nxt;
      end

      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          raw_prev_r <= 1'b0;
          lvl_r      <= 1'b0;
          acc_r      <= 8'h00;
          win_on_r   <= 1'b0;
          win_left_r <= 8'h00;
          ecnt_r     <= 8'h00;
          act_r      <= 1'b0;
          out_r      <= '0;
        end
        else if (ce)
        begin
          raw_prev_r <= raw_prev_nxt;
          lvl_r      <= lvl_nxt;
          acc_r      <= acc_nxt;
          win_on_r   <= win_on_nxt;
          win_left_r <= win_left_nxt;
          ecnt_r     <= ecnt_nxt;
          act_r      <= act_nxt;
          out_r      <= out_nxt;
        end
      end

      assign ch_out[c] = out_r;
    end
  endgenerate
endmodule

// ==== verification/idf_properties.sv ====
`timescale 1ns/1ps
module idf_properties
  import idf_pkg::*;
#(
  parameter int unsigned MS_DIV  = 4,
  parameter int unsigned WIN_DIV = 3
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic [idf_pkg::NUM_CH-1:0] raw_in,
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_def,
  input  idf_pkg::idf_ch_cfg_t            ch_cfg_in  [idf_pkg::NUM_CH],
  input  idf_pkg::idf_grp_cfg_t           grp_cfg_in [idf_pkg::NUM_GRP],
  input  idf_pkg::idf_ch_out_t            ch_out     [idf_pkg::NUM_CH]
);
  import idf_pkg::*;
  // Shadow of the channel 0 and group 0 settings, so that properties know the mode.
  idf_ch_cfg_t  c0_r;
  idf_grp_cfg_t g0_r;
  always_ff @(posedge clock)
  begin
    if (rst || (ce && cfg_def))
    begin
      c0_r <= CH_CFG_DEF;
      g0_r <= GRP_CFG_DEF;
    end
    else if (ce && cfg_wr)
    begin
      c0_r <= ch_cfg_in[0];
      g0_r <= grp_cfg_in[0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_byp;
    ce && c0_r.used && c0_r.deb_ms == 8'h00 && $stable(raw_in[0]) && $stable(c0_r);
  endsequence
  sequence s_off;
    ce && !c0_r.used;
  endsequence
  sequence s_dech_off;
    ce && !g0_r.dech_en && !g0_r.cnt_mode && c0_r.used && $stable(c0_r) && $stable(g0_r);
  endsequence
  sequence s_rise_sel;
    ce && g0_r.cnt_mode && c0_r.edge_sel == EDGE_RISE && $stable(c0_r);
  endsequence
  a_rst_zero: assert property ($fell(rst) |-> ch_out[0] == '0) else $error("outputs not cleared by reset");
  a_bypass_follow: assert property (s_byp [*4] |-> ch_out[0].level == raw_in[0])
    else $error("bypassed level does not follow input");
  a_off_silent: assert property (s_off [*4] |-> !ch_out[0].level && !ch_out[0].valid && !ch_out[0].dech_act)
    else $error("disabled channel not silent");
  a_dech_off_idle: assert property ((ce && !g0_r.dech_en && $stable(g0_r)) [*4] |-> !ch_out[0].dech_act)
    else $error("dechatter active while disabled");
  a_dech_off_pass: assert property (s_dech_off [*4] ##0 $changed(ch_out[0].level) |-> ch_out[0].valid)
    else $error("edge lost without dechatter");
  a_edge_level: assert property (ch_out[0].valid |->
    $changed(ch_out[0].level) && ch_out[0].rising == ch_out[0].level)
    else $error("edge not tied to filtered level");
  a_rise_only: assert property (s_rise_sel [*4] ##0 ch_out[0].valid |-> ch_out[0].rising)
    else $error("falling edge passed in rise mode");
  a_discard_act: assert property ($rose(ch_out[0].dech_act) |-> !ch_out[0].valid && $changed(ch_out[0].level))
    else $error("dechatter active without discarded edge");
  a_freeze_ce: assert property (!ce |=> $stable(ch_out[0])) else $error("outputs moved while clock disabled");
endmodule

bind idf_top idf_properties #(.MS_DIV(MS_DIV), .WIN_DIV(WIN_DIV)) idf_properties_inst (.clock(clock), .rst(rst),
  .ce(ce), .raw_in(raw_in), .cfg_wr(cfg_wr), .cfg_def(cfg_def), .ch_cfg_in(ch_cfg_in), .grp_cfg_in(grp_cfg_in),
  .ch_out(ch_out));

// ==== verification/idf_field.sv ====
`timescale 1ns/1ps
// Field contacts: every channel is wired to one commanded contact level.
module idf_field (
  input  wire logic                       lvl,
  output logic [idf_pkg::NUM_CH-1:0]      raw_in
);
  import idf_pkg::*;
  assign raw_in = {NUM_CH{lvl}};
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import idf_pkg::*;
  localparam int unsigned MS_DIV  = 4;
  localparam int unsigned WIN_DIV = 3;
  localparam logic [1:0]  ES_T [4] = '{EDGE_RISE, EDGE_FALL, EDGE_RISE, EDGE_BOTH};
  localparam logic        CM_T [4] = '{1'h1, 1'h1, 1'h0, 1'h1};
  localparam int          EX_T [4] = '{3, 3, 6, 6};
  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  logic                   ce = 1'b1;
  logic                   lvl = 1'b0;
  logic                   cfg_wr = 1'b0;
  logic                   cfg_def = 1'b0;
  logic [NUM_CH-1:0]      raw_in;
  idf_ch_cfg_t            ch_cfg_in  [NUM_CH];
  idf_grp_cfg_t           grp_cfg_in [NUM_GRP];
  idf_ch_out_t            ch_out     [NUM_CH];
  int                     bad_count = 0;
  int                     samples_checked = 0;
  int                     vcnt = 0;
  logic                   last_rise = 1'b0;
  always #12.5 clock = ~clock;
  idf_field idf_field_inst (.lvl(lvl), .raw_in(raw_in));
  idf_top #(.MS_DIV(MS_DIV), .WIN_DIV(WIN_DIV)) idf_top_inst (.clock(clock), .rst(rst), .ce(ce), .raw_in(raw_in),
    .cfg_wr(cfg_wr), .cfg_def(cfg_def), .ch_cfg_in(ch_cfg_in), .grp_cfg_in(grp_cfg_in), .ch_out(ch_out));
  // Recorded edges of channel 0, as the event recorder would see them.
  always @(posedge clock)
  begin
    if (ch_out[0].valid === 1'b1)
    begin
      vcnt++;
      last_rise = ch_out[0].rising;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cfg(input logic [7:0] deb, input logic [1:0] es, input logic [7:0] cc, input logic [7:0] ct,
                     input logic dt, input logic cm, input logic de, input logic us);
    foreach (ch_cfg_in[i]) ch_cfg_in[i] = '{used: us, deb_ms: deb, edge_sel: es, chat_cnt: cc, chat_time: ct};
    foreach (grp_cfg_in[i]) grp_cfg_in[i] = '{deb_type: dt, cnt_mode: cm, dech_en: de};
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    step(1);
  endtask
  // Field 0 watches the level, field 1 the dechatter status; a spent bound ends the run.
  task automatic wait_out(input int f, input logic exp, input int lim, output int n);
    n = 0;
    while (((f != 0) ? ch_out[0].dech_act : ch_out[0].level) !== exp && n < lim)
    begin
      step(1);
      n++;
    end
    if (n >= lim)
    begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic burst(input int k, output int v);
    v = vcnt;
    repeat (k)
    begin
      lvl = ~lvl;
      step(2);
    end
    step(4);
    v = vcnt - v;
  endtask
  initial
  begin
    int n;
    int v;
    foreach (ch_cfg_in[i]) ch_cfg_in[i] = CH_CFG_DEF;
    foreach (grp_cfg_in[i]) grp_cfg_in[i] = GRP_CFG_DEF;
    step(2);
    rst = 1'b0;
    check(ch_out[0], 4'h0);
    lvl = 1'b1;
    wait_out(0, 1'b1, 20, n);
    check(n >= 3 && n <= 12, 1'b1);
    lvl = 1'b0;
    cfg(8'h00, EDGE_BOTH, 8'h01, 8'h01, DBT_STEADY, 1'b0, 1'b0, 1'b1);
    step(3);
    check(ch_out[0].level, 1'b0);
    burst(6, v);
    check(v, 6);
    ce = 1'b0;
    lvl = 1'b1;
    step(4);
    check(ch_out[0].level, 1'b0);
    lvl = 1'b0;
    ce = 1'b1;
    step(3);
    for (int e = 0; e < 4; e++)
    begin
      cfg(8'h00, ES_T[e], 8'h01, 8'h01, DBT_STEADY, CM_T[e], 1'b0, 1'b1);
      burst(6, v);
      check(v, EX_T[e]);
      if (e < 2) check(last_rise, e == 0);
    end
    cfg(8'h00, EDGE_BOTH, 8'h02, 8'h02, DBT_STEADY, 1'b0, 1'b1, 1'b1);
    burst(5, v);
    check(v, 2);
    check(ch_out[0].dech_act, 1'b1);
    wait_out(1, 1'b0, 40, n);
    check(n <= 28, 1'b1);
    step(20);
    burst(1, v);
    check(v, 1);
    cfg(8'h00, EDGE_BOTH, 8'h01, 8'h01, DBT_STEADY, 1'b0, 1'b1, 1'b1);
    // The window opened by the single edge above must run out first, or both edges are discarded.
    step(24);
    burst(2, v);
    check(v, 1);
    wait_out(1, 1'b0, 40, n);
    burst(1, v);
    check(v + last_rise, 2);
    lvl = 1'b0;
    cfg(8'h02, EDGE_BOTH, 8'h01, 8'h01, DBT_STEADY, 1'b0, 1'b0, 1'b1);
    wait_out(0, 1'b0, 30, n);
    lvl = 1'b1;
    step(6);
    lvl = 1'b0;
    step(1);
    lvl = 1'b1;
    wait_out(0, 1'b1, 30, n);
    check(n >= 7, 1'b1);
    lvl = 1'b0;
    wait_out(0, 1'b0, 30, n);
    cfg(8'h03, EDGE_BOTH, 8'h01, 8'h01, DBT_INTEG, 1'b0, 1'b0, 1'b1);
    lvl = 1'b1;
    step(10);
    lvl = 1'b0;
    step(2);
    lvl = 1'b1;
    wait_out(0, 1'b1, 30, n);
    check(n <= 11, 1'b1);
    cfg(8'h00, EDGE_BOTH, 8'h01, 8'h01, DBT_STEADY, 1'b0, 1'b0, 1'b0);
    burst(3, v);
    check(v, 0);
    check(ch_out[0].level, 1'b0);
    cfg_def = 1'b1;
    step(1);
    cfg_def = 1'b0;
    lvl = 1'b1;
    wait_out(0, 1'b1, 20, n);
    check(n >= 3, 1'b1);
    // Every channel sees the same contact and the same defaults, so all must agree.
    foreach (ch_out[i]) check(ch_out[i].level, 1'b1);
    give_verdict();
  end
endmodule
